// ### ppc_pkg.sv
// Purpose: Shared constants for the port pad pull control block
// Assumes: APB slave with 32-bit data, 8-bit byte address
// Notes:   Pin index 15:0 port A, 31:16 port B, 46:32 port C
`default_nettype none

package ppc_pkg;

   // ****************************************
   // Pin counts
   // ****************************************
   localparam int NPIN   = 47;
   localparam int NPC    = 15;
   localparam int PC_LSB = 32;
   localparam int NFN    = 4;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_A_IEN  = 8'h04;
   localparam logic [7:0] OFS_A_OEN  = 8'h08;
   localparam logic [7:0] OFS_A_DATA = 8'h0C;
   localparam logic [7:0] OFS_B_IEN  = 8'h10;
   localparam logic [7:0] OFS_B_OEN  = 8'h14;
   localparam logic [7:0] OFS_B_DATA = 8'h18;
   localparam logic [7:0] OFS_C_IEN  = 8'h1C;
   localparam logic [7:0] OFS_C_OEN  = 8'h20;
   localparam logic [7:0] OFS_C_FSEL = 8'h24;
   localparam logic [7:0] OFS_PU_AB  = 8'h28;
   localparam logic [7:0] OFS_PU_C   = 8'h2C;
   localparam logic [7:0] OFS_DIN_AB = 8'h30;
   localparam logic [7:0] OFS_DIN_C  = 8'h34;
   localparam logic [7:0] OFS_PD_ALL = 8'h38;

   // ****************************************
   // Control field positions
   // ****************************************
   localparam int CTRL_POLICY = 0;
   localparam int CTRL_RUN    = 1;
   localparam int CTRL_CHM    = 2;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [NPIN-1:0]  RST_EN   = 47'h0;
   localparam logic [31:0]      RST_DATA = 32'h0;
   localparam logic [2*NPC-1:0] RST_FSEL = 30'h0;

   // ****************************************
   // Fixed pin tables
   // ****************************************
   // Strobe and select-output pins that get a pull-down instead of a pull-up
   localparam logic [NPIN-1:0]  PD_PIN_MASK = {15'h0400, 16'h8370, 16'h4078};
   // Port C pins with a card-host function, and which slot holds it
   localparam logic [NPC-1:0]   CH_PIN_MASK = 15'h07F0;
   localparam logic [2*NPC-1:0] CH_FN_SLOT  = 30'h001AAA00;
   // Port C pins with an input tap, and the wake-source pin
   localparam logic [NPC-1:0]   TAP_MASK    = 15'h069E;
   localparam int               WAKE_PIN    = 2;

endpackage : ppc_pkg

`default_nettype wire

// ### ppc_pad_if.sv
// Purpose: Carrier between the pad controller and its per-pin decision logic
// Assumes: One clock domain, all signals combinational levels
// Notes:   Output enable is active high here, active low at the pads
`default_nettype none

interface ppc_pad_if;
   import ppc_pkg::*;
   logic [NPIN-1:0] ie;
   logic [NPIN-1:0] oe;
   logic [NPIN-1:0] ch;
   logic [NPIN-1:0] pdm;
   logic            policy;
   logic            run;
   logic [NPIN-1:0] pu;
   logic [NPIN-1:0] pd;
   logic [NPIN-1:0] drive_n;

   modport ctl (output ie, oe, ch, pdm, policy, run, input pu, pd, drive_n);
   modport dec (input ie, oe, ch, pdm, policy, run, output pu, pd, drive_n);
endinterface : ppc_pad_if

`default_nettype wire

// ### ppc_pad_decide.sv
// Purpose: Per-pin pull-up, pull-down and drive decision
// Assumes: run is low from reset until software starts
// Notes:   Purely combinational; the top registers every result
`default_nettype none

module ppc_pad_decide
   import ppc_pkg::*;
(
   ppc_pad_if.dec pif
);

   genvar i;
   generate
      for (i = 0; i < NPIN; i++)
      begin : g_pin
         // Pull-down pins never take a pull-up, even during boot
         assign pif.pu[i] = ~pif.pdm[i] & (~pif.run |
                            (~pif.ch[i] & ~pif.oe[i]
                             & (pif.policy | ~pif.ie[i])));
         assign pif.pd[i] = pif.pdm[i] & pif.run & ~pif.oe[i];
         assign pif.drive_n[i] = ~(pif.run & pif.oe[i]);
      end
   endgenerate

endmodule : ppc_pad_decide

`default_nettype wire

// ### ppc_top.sv
// Purpose: Pad pull and drive control for ports A, B and C
// Assumes: APB master keeps the request stable until PREADY
// Notes:   One wait state on every access; all outputs registered
//
// Function
// - Under reset and before code runs, every port pad is left undriven.
// - After reset release, until code runs, every port pin except the pull-down pins is pulled up.
// - Once code runs, pad state follows each pin's input and output enable.
// - Policy 0: pull-up only when input and output enable are both off.
// - Policy 1: pull-up whenever output enable is off.
// - Once code runs, pins routed to the card-host function never get a pull-up.
// - Once code runs, strobe, ready and select-output pins get a pull-down while output is off.
// - Each port C pin takes one of four functions; some feed input taps.
`default_nettype none

module ppc_top
   import ppc_pkg::*;
(
   input  wire logic                SYS_CLK,
   input  wire logic                RST_N,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic [NPIN-1:0]     PAD_DIN,
   input  wire logic [NFN*NPC-1:0]  PC_FUNC_DOUT,
   output logic      [NPIN-1:0]     PAD_DOUT,
   output logic      [NPIN-1:0]     PAD_OE_N,
   output logic      [NPIN-1:0]     PAD_PU_EN,
   output logic      [NPIN-1:0]     PAD_PD_EN,
   output logic      [NPC-1:0]      PC_TAP,
   output logic                     SYSTEM_WAKE_SOURCE_3
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [NPIN-1:0]  din_meta_ff;
   logic [NPIN-1:0]  din_sync_ff;
   logic             pready_ff;
   logic             pslverr_ff;
   logic [31:0]      prdata_ff;
   logic [31:0]      nxt_prdata;
   logic             nxt_hit;
   logic [NPIN-1:0]  ie_ff;
   logic [NPIN-1:0]  oe_ff;
   logic [31:0]      dat_ff;
   logic [2*NPC-1:0] fsel_ff;
   logic             policy_ff;
   logic             run_ff;
   logic             chm_ff;
   logic [NPIN-1:0]  ch_vec;
   logic [NPC-1:0]   nxt_cdout;
   logic [NPIN-1:0]  pu_ff;
   logic [NPIN-1:0]  pd_ff;
   logic [NPIN-1:0]  oe_n_ff;
   logic [NPIN-1:0]  dout_ff;
   logic [NPC-1:0]   tap_ff;
   logic             wake_ff;
   logic             acc;
   logic             wr;

   ppc_pad_if pif ();

   // ****************************************
   // Pad input synchroniser
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         din_meta_ff <= RST_EN;
         din_sync_ff <= RST_EN;
      end
      else
      begin
         din_meta_ff <= PAD_DIN;
         din_sync_ff <= din_meta_ff;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   assign acc = PSEL & PENABLE;
   // Write lands only at the edge where PREADY is seen high
   assign wr  = acc & pready_ff & PWRITE;

   always_comb
   begin
      nxt_prdata = 32'h0;
      nxt_hit    = 1'b1;
      if (PADDR == OFS_CTRL)
         nxt_prdata[2:0] = {chm_ff, run_ff, policy_ff};
      else if (PADDR == OFS_A_IEN)
         nxt_prdata[15:0] = ie_ff[15:0];
      else if (PADDR == OFS_A_OEN)
         nxt_prdata[15:0] = oe_ff[15:0];
      else if (PADDR == OFS_A_DATA)
         nxt_prdata[15:0] = dat_ff[15:0];
      else if (PADDR == OFS_B_IEN)
         nxt_prdata[15:0] = ie_ff[31:16];
      else if (PADDR == OFS_B_OEN)
         nxt_prdata[15:0] = oe_ff[31:16];
      else if (PADDR == OFS_B_DATA)
         nxt_prdata[15:0] = dat_ff[31:16];
      else if (PADDR == OFS_C_IEN)
         nxt_prdata[NPC-1:0] = ie_ff[NPIN-1:PC_LSB];
      else if (PADDR == OFS_C_OEN)
         nxt_prdata[NPC-1:0] = oe_ff[NPIN-1:PC_LSB];
      else if (PADDR == OFS_C_FSEL)
         nxt_prdata[2*NPC-1:0] = fsel_ff;
      else if (PADDR == OFS_PU_AB)
         nxt_prdata = pu_ff[31:0];
      else if (PADDR == OFS_PU_C)
         nxt_prdata[NPC-1:0] = pu_ff[NPIN-1:PC_LSB];
      else if (PADDR == OFS_DIN_AB)
         nxt_prdata = din_sync_ff[31:0];
      else if (PADDR == OFS_DIN_C)
         nxt_prdata[NPC-1:0] = din_sync_ff[NPIN-1:PC_LSB];
      else if (PADDR == OFS_PD_ALL)
         nxt_prdata = pd_ff[31:0] | {17'h0, pd_ff[NPIN-1:PC_LSB]};
      else
         nxt_hit = 1'b0;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= RST_DATA;
      end
      else
      begin
         pready_ff  <= acc & ~pready_ff;
         pslverr_ff <= acc & ~pready_ff & ~nxt_hit;
         if (acc & ~pready_ff & ~PWRITE)
            prdata_ff <= nxt_prdata;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         policy_ff <= 1'b0;
         run_ff    <= 1'b0;
         chm_ff    <= 1'b0;
      end
      else if (wr && PADDR == OFS_CTRL)
      begin
         policy_ff <= PWDATA[CTRL_POLICY];
         // Code start is one-way: only reset returns to the boot phase
         run_ff    <= run_ff | PWDATA[CTRL_RUN];
         chm_ff    <= PWDATA[CTRL_CHM];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ie_ff   <= RST_EN;
         oe_ff   <= RST_EN;
         dat_ff  <= RST_DATA;
         fsel_ff <= RST_FSEL;
      end
      else if (wr)
      begin
         if (PADDR == OFS_A_IEN)
            ie_ff[15:0] <= PWDATA[15:0];
         else if (PADDR == OFS_A_OEN)
            oe_ff[15:0] <= PWDATA[15:0];
         else if (PADDR == OFS_A_DATA)
            dat_ff[15:0] <= PWDATA[15:0];
         else if (PADDR == OFS_B_IEN)
            ie_ff[31:16] <= PWDATA[15:0];
         else if (PADDR == OFS_B_OEN)
            oe_ff[31:16] <= PWDATA[15:0];
         else if (PADDR == OFS_B_DATA)
            dat_ff[31:16] <= PWDATA[15:0];
         else if (PADDR == OFS_C_IEN)
            ie_ff[NPIN-1:PC_LSB] <= PWDATA[NPC-1:0];
         else if (PADDR == OFS_C_OEN)
            oe_ff[NPIN-1:PC_LSB] <= PWDATA[NPC-1:0];
         else if (PADDR == OFS_C_FSEL)
            fsel_ff <= PWDATA[2*NPC-1:0];
      end
   end

   // ****************************************
   // Port C function routing
   // ****************************************
   genvar j;
   generate
      for (j = 0; j < NPC; j++)
      begin : g_pc
         assign nxt_cdout[j] = PC_FUNC_DOUT[fsel_ff[2*j+:2]*NPC+j];
         assign ch_vec[PC_LSB+j] = chm_ff & CH_PIN_MASK[j]
                                   & (fsel_ff[2*j+:2] == CH_FN_SLOT[2*j+:2]);
      end
   endgenerate
   assign ch_vec[PC_LSB-1:0] = 32'h0;

   // ****************************************
   // Pad decision and output registers
   // ****************************************
   assign pif.ie     = ie_ff;
   assign pif.oe     = oe_ff;
   assign pif.ch     = ch_vec;
   assign pif.pdm    = PD_PIN_MASK;
   assign pif.policy = policy_ff;
   assign pif.run    = run_ff;

   ppc_pad_decide u_decide (
      .pif (pif.dec)
   );

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         // Reset leaves every pad floating with no pull
         pu_ff   <= RST_EN;
         pd_ff   <= RST_EN;
         oe_n_ff <= ~RST_EN;
         dout_ff <= RST_EN;
         tap_ff  <= RST_EN[NPC-1:0];
         wake_ff <= 1'b0;
      end
      else
      begin
         pu_ff   <= pif.pu;
         pd_ff   <= pif.pd;
         oe_n_ff <= pif.drive_n;
         dout_ff <= {nxt_cdout, dat_ff};
         tap_ff  <= din_sync_ff[NPIN-1:PC_LSB] & TAP_MASK;
         wake_ff <= din_sync_ff[PC_LSB+WAKE_PIN];
      end
   end

   assign PRDATA               = prdata_ff;
   assign PREADY               = pready_ff;
   assign PSLVERR              = pslverr_ff;
   assign PAD_DOUT             = dout_ff;
   assign PAD_OE_N             = oe_n_ff;
   assign PAD_PU_EN            = pu_ff;
   assign PAD_PD_EN            = pd_ff;
   assign PC_TAP               = tap_ff;
   assign SYSTEM_WAKE_SOURCE_3 = wake_ff;

   // ****************************************
   // Assertions
   // ****************************************
   // Look-backs across a reset see pipeline stages still at their reset values,
   // so the boot pull-up, wake-tap and function-routing checks wait until the pad pipeline has refilled
   logic [1:0] ast_age_ff;

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         ast_age_ff <= 2'h0;
      else if (ast_age_ff != 2'h3)
         ast_age_ff <= ast_age_ff + 2'h1;
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   logic [NPIN-1:0] excl;
   assign excl = ch_vec | PD_PIN_MASK;

   AST_BOOT_NODRIVE: assert property (!$past(run_ff) |-> &PAD_OE_N)
      else $error("Pad driven before code start");
   AST_BOOT_PULLUP: assert property (ast_age_ff != 2'h0 && !$past(run_ff) |->
      (PAD_PU_EN == ~PD_PIN_MASK) && (PAD_PD_EN == 47'h0))
      else $error("Boot pull-up pattern wrong");
   AST_RUN_DRIVE: assert property ($past(run_ff) |-> PAD_OE_N == ~$past(oe_ff))
      else $error("Pad drive does not follow output enable");
   AST_POLICY0: assert property ($past(run_ff & ~policy_ff) |->
      (PAD_PU_EN & ~$past(excl)) == (~$past(ie_ff | oe_ff) & ~$past(excl)))
      else $error("Policy 0 pull-up wrong");
   AST_POLICY1: assert property ($past(run_ff & policy_ff) |->
      (PAD_PU_EN & ~$past(excl)) == (~$past(oe_ff) & ~$past(excl)))
      else $error("Policy 1 pull-up wrong");
   AST_CARD_NOPULL: assert property ($past(run_ff) |->
      (PAD_PU_EN & $past(ch_vec)) == 47'h0)
      else $error("Pull-up on card-host pin");
   AST_PULLDOWN: assert property ($past(run_ff) |->
      PAD_PD_EN == (~$past(oe_ff) & PD_PIN_MASK))
      else $error("Pull-down pattern wrong");
   AST_WAKE_TAP: assert property (ast_age_ff == 2'h3 |->
      SYSTEM_WAKE_SOURCE_3 == $past(PAD_DIN[PC_LSB+WAKE_PIN], 3))
      else $error("Wake tap not following pin");
   AST_NO_CONFLICT: assert property ((PAD_PU_EN & PAD_PD_EN) == 47'h0)
      else $error("Pull-up and pull-down together");

   generate
      for (j = 0; j < NPC; j++)
      begin : g_ast
         for (genvar k = 0; k < NFN; k++)
         begin : g_fn
            AST_FUNC_ROUTE: assert property (ast_age_ff != 2'h0 &&
               $past(fsel_ff[2*j+:2] == k) |->
               PAD_DOUT[PC_LSB+j] == $past(PC_FUNC_DOUT[k*NPC+j]))
               else $error("Port C function routing wrong");
         end
      end
   endgenerate

   COV_RUN_START: cover property (!run_ff ##1 run_ff);
   COV_POLICY1:   cover property (run_ff && policy_ff && (oe_ff == 47'h0));
   COV_CARD_PIN:  cover property (run_ff && (ch_vec != 47'h0));
   COV_PD_ACTIVE: cover property (PAD_PD_EN != 47'h0);

endmodule : ppc_top

`default_nettype wire

// ### ppc_board_model.sv
// Purpose: Board-side model of the port pads, resolving each pad's level
// Assumes: The bench drives a pad externally only where the device does not
// Notes:   A pad nobody drives or pulls toggles every cycle, so it never reads stable
`default_nettype none

module ppc_board_model
   import ppc_pkg::*;
(
   input  wire logic            clk,
   input  wire logic [NPIN-1:0] oe_n,
   input  wire logic [NPIN-1:0] dout,
   input  wire logic [NPIN-1:0] pu_en,
   input  wire logic [NPIN-1:0] pd_en,
   input  wire logic [NPIN-1:0] ext_en,
   input  wire logic [NPIN-1:0] ext_val,
   output logic      [NPIN-1:0] din
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [NPIN-1:0] float_ff = '0;

   always @(posedge clk)
   begin
      float_ff <= ~float_ff;
   end

   // Device drive wins, then the board, then the weak pulls
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         if (!oe_n[i])
            din[i] = dout[i];
         else if (ext_en[i])
            din[i] = ext_val[i];
         else if (pu_en[i])
            din[i] = 1'b1;
         else if (pd_en[i])
            din[i] = 1'b0;
         else
            din[i] = float_ff[i];
      end
   end
endmodule : ppc_board_model

`default_nettype wire

// ### ppc_tb.sv
// Purpose: Self-checking bench for the port pad pull controller
// Assumes: APB slave answers within a few cycles
// Notes:   Pad outputs are checked three edges after the last register write
`default_nettype none

module tb
   import ppc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [NFN*NPC-1:0] func = {15'h7A5C, 15'h1E3F, 15'h4C81, 15'h2B96};
   logic [NPIN-1:0] ext_en = '0;
   logic [NPIN-1:0] ext_val = '0;
   logic [NPIN-1:0] din, dout, oe_n, pu, pd, ie, oe, ch;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, wake;
   logic [NPC-1:0] tap;
   int fails = 0;
   int checked = 0;

   ppc_top i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PAD_DIN(din), .PC_FUNC_DOUT(func), .PAD_DOUT(dout),
      .PAD_OE_N(oe_n), .PAD_PU_EN(pu), .PAD_PD_EN(pd), .PC_TAP(tap),
      .SYSTEM_WAKE_SOURCE_3(wake));

   ppc_board_model i_board (.clk(sys_clk), .oe_n(oe_n), .dout(dout), .pu_en(pu),
      .pd_en(pd), .ext_en(ext_en), .ext_val(ext_val), .din(din));

   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic report_and_stop;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checked++;
      // Only the pad-wide low bits carry data; a widening cast may fill the rest
      if (g[NPIN-1:0] !== e[NPIN-1:0])
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e[NPIN-1:0], g[NPIN-1:0]);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fails++;
         report_and_stop();
      end
   endtask : apb

   task automatic set_en;
      apb(1'b1, OFS_A_IEN, 32'(ie[15:0]));
      apb(1'b1, OFS_A_OEN, 32'(oe[15:0]));
      apb(1'b1, OFS_B_IEN, 32'(ie[31:16]));
      apb(1'b1, OFS_B_OEN, 32'(oe[31:16]));
      apb(1'b1, OFS_C_IEN, 32'(ie[46:32]));
      apb(1'b1, OFS_C_OEN, 32'(oe[46:32]));
   endtask : set_en

   // Expected pulls worked out per pin from the enables and the fixed tables
   task automatic pads(input logic pol);
      logic [NPIN-1:0] off;
      off = ~oe & ~PD_PIN_MASK & ~ch;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("oe_n", 64'(~oe), 64'(oe_n));
      chk("pu", 64'(pol ? off : off & ~ie), 64'(pu));
      chk("pd", 64'(~oe & PD_PIN_MASK), 64'(pd));
      chk("pu_pd", 64'h0, 64'(pu & pd));
   endtask : pads

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      repeat (20) @(posedge sys_clk);
      chk("oe_n_rst", 64'(~47'h0), 64'(oe_n));
      chk("pu_rst", 64'h0, 64'(pu | pd));
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("pu_boot", 64'(~PD_PIN_MASK), 64'(pu));
      chk("pd_boot", 64'h0, 64'(pd));
      apb(1'b1, OFS_A_OEN, 32'h0000FFFF);
      repeat (3) @(posedge sys_clk);
      chk("oe_n_boot", 64'(~47'h0), 64'(oe_n));
      ie = {15'h0F0F, 16'hFF00, 16'h00FF};
      oe = {15'h0003, 16'h00F0, 16'h0F0F};
      ch = '0;
      set_en();
      apb(1'b1, OFS_CTRL, 32'h00000002);
      pads(1'b0);
      apb(1'b1, OFS_CTRL, 32'h00000003);
      pads(1'b1);
      oe[46:32] = '0;
      ch = {CH_PIN_MASK, 32'h0};
      set_en();
      apb(1'b1, OFS_C_FSEL, 32'(CH_FN_SLOT));
      apb(1'b1, OFS_CTRL, 32'h00000007);
      pads(1'b1);
      apb(1'b0, OFS_C_FSEL, 32'h0);
      chk("fsel", 64'(CH_FN_SLOT), 64'(rd));
      for (int k = 0; k < NFN; k++)
      begin
         apb(1'b1, OFS_C_FSEL, 32'({NPC{2'(k)}}));
         repeat (3) @(posedge sys_clk);
         chk("pc_dout", 64'(func[k*NPC +: NPC]), 64'(dout[46:32]));
      end
      ext_en <= {15'h7FFF, 32'h0};
      for (int v = 0; v < 2; v++)
      begin
         ext_val <= {(v == 0) ? 15'h2AD5 : 15'h552A, 32'h0};
         repeat (5) @(posedge sys_clk);
         chk("tap", 64'(ext_val[46:32] & TAP_MASK), 64'(tap));
         chk("wake", 64'(ext_val[PC_LSB + WAKE_PIN]), 64'(wake));
         apb(1'b0, OFS_DIN_C, 32'h0);
         chk("din_c", 64'(ext_val[46:32]), 64'(rd));
      end
      apb(1'b1, OFS_A_DATA, 32'h0000A5C3);
      repeat (3) @(posedge sys_clk);
      chk("a_dout", 64'h0000A5C3, 64'(dout[15:0]));
      apb(1'b0, 8'h3C, 32'h0);
      chk("bad_err", 64'h1, 64'(err));
      chk("bad_rd", 64'h0, 64'(rd));
      rst_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("oe_n_rst2", 64'(~47'h0), 64'(oe_n));
      chk("pu_rst2", 64'h0, 64'(pu | pd));
      @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("pu_boot2", 64'(~PD_PIN_MASK), 64'(pu));
      report_and_stop();
   end
endmodule : tb

`default_nettype wire
